// file: core/pid_pkg.sv
package pid_pkg;
  // values are tenths of a percent: 1000 is 100.0 %
  localparam int VAL_W          = 16;
  localparam int SEL_W          = 5;
  localparam int SRC_COUNT      = 12;
  localparam int PCT_FULL       = 1000;
  localparam int PROP_GAIN_SCALE    = 100;
  localparam int INTEG_TIME_UNIT_MS = 10;
  localparam int DERIV_TIME_UNIT_MS = 10;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int NS_PER_MS      = 1000000;
  localparam int CYCLES_PER_MS  = NS_PER_MS / CLK_PERIOD_NS;

  localparam logic [3:0] FREQ_CMD_PID     = 4'h7;
  localparam logic [3:0] VOLT_CHAN_PID    = 4'h6;
  // feedback codes from this one upward skip the multi-step source
  localparam logic [3:0] FB_SRC_MODBUS    = 4'h4;
  localparam int         OPT_HALT_LSB     = 0;
  localparam logic [3:0] OPT_HALT_INTEG   = 4'h1;

  localparam int KEYPAD_REF_DEFAULT = 0;
  localparam int PROP_GAIN_DEFAULT  = 180;
  localparam int INTEG_TIME_DEFAULT = 90;
  localparam int DERIV_TIME_DEFAULT = 0;
  localparam int SAMPLE_MS_DEFAULT  = 100;
  localparam int DEV_LIMIT_DEFAULT  = 0;
  localparam int UPPER_DEFAULT      = 1000;
  localparam int LOWER_DEFAULT      = 0;
  localparam logic [15:0] OPTION_DEFAULT = 16'h0001;
endpackage

// file: core/signal_select.sv
`timescale 1ns/1ps
module signal_select #(
  parameter int N     = 12,
  parameter int W     = 16,
  parameter int SEL_W = 5
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic [N*W-1:0]   sources_in,
  input  wire logic [SEL_W-1:0] sel_in,
  output logic      [W-1:0]     value_out
);
  if (N > (1 << SEL_W)) begin : g_bad_sel
    $error("signal_select: selector too narrow for source count");
  end

  // unused and reserved codes select zero so the loop sees no stale value
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      value_out <= '0;
    end else if (int'(sel_in) < N) begin
      value_out <= sources_in[int'(sel_in)*W +: W];
    end else begin
      value_out <= '0;
    end
  end
endmodule

// file: core/process_pid_regulator.sv
`timescale 1ns/1ps
// How it works
// - deviation of reference and feedback drives output as negative feedback
// - proportional term is gain times present deviation
// - integral accumulates deviation each sample, scaled by integral time
// - derivative term follows change of deviation, scaled by derivative time
// - regulator active when either frequency selector is 7 or voltage channel is 6
// - reference selector codes 0..12, keypad by default, 12 reserved
// - keypad reference is signed, -100 to +100 percent, default zero
// - feedback selector codes 0..10, analog, pulse, buses, card, 10 reserved
// - polarity bit 1 inverts the regulator sense
// - derivative time zero means no derivative action
// - deviation limit 0..100 percent, default zero; deviations at or below it are ignored
// - upper limit from lower limit to 100 percent, default 100 percent
// - lower limit from -100 percent to upper limit, default zero; the code clamps it to -100..+100 percent and raises the upper limit to meet it
// - option ones digit 1 halts integration while output sits at a limit
module process_pid_regulator #(
  parameter int CYCLES_PER_MS = pid_pkg::CYCLES_PER_MS
) (
  input  wire logic                               clk_in,
  input  wire logic                               rst_n_in,
  input  wire logic [3:0]                         frequency_command_select_a_in,
  input  wire logic [3:0]                         frequency_command_select_b_in,
  input  wire logic [3:0]                         voltage_setup_channel_in,
  input  wire logic [3:0]                         reference_source_select_in,
  input  wire logic signed [pid_pkg::VAL_W-1:0]   keypad_preset_reference_in,
  input  wire logic [3:0]                         feedback_source_select_in,
  input  wire logic                               output_polarity_select_in,
  input  wire logic [15:0]                        proportional_gain_setting_in,
  input  wire logic [15:0]                        integral_time_setting_in,
  input  wire logic [15:0]                        derivative_time_setting_in,
  input  wire logic [15:0]                        sampling_period_setting_in,
  input  wire logic [15:0]                        deviation_limit_setting_in,
  input  wire logic signed [pid_pkg::VAL_W-1:0]   output_upper_limit_in,
  input  wire logic signed [pid_pkg::VAL_W-1:0]   output_lower_limit_in,
  input  wire logic [15:0]                        control_option_digits_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          analog_input_one_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          analog_input_two_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          analog_input_three_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          pulse_input_a_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          pulse_input_b_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          multi_step_value_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          modbus_value_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          fieldbus_value_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          ethernet_value_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          ethercat_value_in,
  input  wire logic [pid_pkg::VAL_W-1:0]          prog_card_value_in,
  output logic                                    pid_active_out,
  output logic                                    sample_strobe_out,
  output logic                                    output_limited_out,
  output logic signed [pid_pkg::VAL_W-1:0]        regulator_out
);
  import pid_pkg::*;

  if (CYCLES_PER_MS < 1) begin : g_bad_rate
    $error("process_pid_regulator: CYCLES_PER_MS must be at least 1");
  end

  typedef logic signed [31:0] word_t;

  function automatic word_t clamp(input word_t v, input word_t lo, input word_t hi);
    if (v > hi) return hi;
    if (v < lo) return lo;
    return v;
  endfunction

  function automatic word_t sx(input logic [VAL_W-1:0] v);
    return word_t'($signed(v));
  endfunction

  function automatic logic [SEL_W-1:0] fb_to_src(input logic [3:0] code);
    if (code < FB_SRC_MODBUS) return SEL_W'(code) + SEL_W'(1);
    return SEL_W'(code) + SEL_W'(2);
  endfunction

  // settings shadow, range-limited; reset gives the documented defaults
  word_t       keypad_r, prop_gain_r, integ_time_r, deriv_time_r;
  word_t       period_ms_r, lim_r, upper_r, lower_r;
  logic        pol_r;
  logic        halt_r;
  word_t       lower_c, upper_c;

  always_comb begin
    lower_c = clamp(sx(output_lower_limit_in), -PCT_FULL, PCT_FULL);
    upper_c = clamp(sx(output_upper_limit_in), lower_c, PCT_FULL);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      keypad_r    <= KEYPAD_REF_DEFAULT;
      prop_gain_r  <= PROP_GAIN_DEFAULT;
      integ_time_r <= INTEG_TIME_DEFAULT;
      deriv_time_r <= DERIV_TIME_DEFAULT;
      period_ms_r <= SAMPLE_MS_DEFAULT;
      lim_r       <= DEV_LIMIT_DEFAULT;
      upper_r     <= UPPER_DEFAULT;
      lower_r     <= LOWER_DEFAULT;
      pol_r       <= 1'b0;
      halt_r      <= OPTION_DEFAULT[OPT_HALT_LSB +: 4] == OPT_HALT_INTEG;
    end else begin
      keypad_r    <= clamp(sx(keypad_preset_reference_in), -PCT_FULL, PCT_FULL);
      prop_gain_r  <= word_t'({16'h0000, proportional_gain_setting_in});
      integ_time_r <= word_t'({16'h0000, integral_time_setting_in});
      deriv_time_r <= word_t'({16'h0000, derivative_time_setting_in});
      period_ms_r <= word_t'({16'h0000, sampling_period_setting_in});
      lim_r       <= clamp(word_t'({16'h0000, deviation_limit_setting_in}), 0, PCT_FULL);
      upper_r     <= upper_c;
      lower_r     <= lower_c;
      pol_r       <= output_polarity_select_in;
      halt_r      <= control_option_digits_in[OPT_HALT_LSB +: 4] == OPT_HALT_INTEG;
    end
  end

  // source selection: both selectors index one common source table
  logic [SRC_COUNT*VAL_W-1:0] sources;
  logic [VAL_W-1:0]           ref_sel;
  logic [VAL_W-1:0]           fb_sel;

  assign sources = {prog_card_value_in, ethercat_value_in, pulse_input_b_in, ethernet_value_in,
                    fieldbus_value_in, modbus_value_in, multi_step_value_in, pulse_input_a_in,
                    analog_input_three_in, analog_input_two_in, analog_input_one_in,
                    keypad_r[VAL_W-1:0]};

  signal_select #(.N(SRC_COUNT), .W(VAL_W), .SEL_W(SEL_W)) u_ref_select (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .sources_in (sources),
    .sel_in     ({1'b0, reference_source_select_in}),
    .value_out  (ref_sel)
  );

  signal_select #(.N(SRC_COUNT), .W(VAL_W), .SEL_W(SEL_W)) u_fb_select (
    .clk_in     (clk_in),
    .rst_n_in   (rst_n_in),
    .sources_in (sources),
    .sel_in     (fb_to_src(feedback_source_select_in)),
    .value_out  (fb_sel)
  );

  // mode decode and sample timer
  logic        mode_nxt;
  logic        active_r;
  logic [31:0] cnt_r;
  logic [31:0] period_cycles;
  logic        tick_r;

  assign mode_nxt = (frequency_command_select_a_in == FREQ_CMD_PID) ||
                    (frequency_command_select_b_in == FREQ_CMD_PID) ||
                    (voltage_setup_channel_in == VOLT_CHAN_PID);
  // a zero sampling period degenerates to one sample per clock
  assign period_cycles = (period_ms_r == 0) ? 32'd1 :
                         32'(period_ms_r) * 32'(CYCLES_PER_MS);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      active_r <= 1'b0;
    end else begin
      active_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (!active_r) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else if (cnt_r == 0) begin
      cnt_r  <= period_cycles - 32'd1;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r - 32'd1;
      tick_r <= 1'b0;
    end
  end

  // arithmetic; divisions are wide but only sampled once per period
  word_t raw_dev, abs_dev, dev, p_term, inc, d_term, integ_nxt, integ_use, sum;
  word_t dev_prev_r, integ_r, out_nxt;
  logic  limited_r;
  logic  halt_now;

  always_comb begin
    raw_dev   = pol_r ? sx(fb_sel) - sx(ref_sel) : sx(ref_sel) - sx(fb_sel);
    abs_dev   = (raw_dev < 0) ? -raw_dev : raw_dev;
    dev       = (abs_dev <= lim_r) ? 0 : raw_dev;
    p_term    = (dev * prop_gain_r) / PROP_GAIN_SCALE;
    inc       = (integ_time_r == 0) ? 0 :
                (dev * period_ms_r) / (integ_time_r * INTEG_TIME_UNIT_MS);
    d_term    = (deriv_time_r == 0 || period_ms_r == 0) ? 0 :
                ((dev - dev_prev_r) * deriv_time_r * DERIV_TIME_UNIT_MS) /
                period_ms_r;
    integ_nxt = clamp(integ_r + inc, -PCT_FULL, PCT_FULL);
    halt_now  = halt_r && limited_r;
    integ_use = halt_now ? integ_r : integ_nxt;
    sum       = p_term + integ_use + d_term;
    out_nxt   = clamp(sum, lower_r, upper_r);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      integ_r    <= '0;
      dev_prev_r <= '0;
    end else if (!active_r) begin
      integ_r    <= '0;
      dev_prev_r <= '0;
    end else if (tick_r) begin
      integ_r    <= integ_use;
      dev_prev_r <= dev;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      regulator_out      <= '0;
      limited_r          <= 1'b0;
      sample_strobe_out  <= 1'b0;
      pid_active_out     <= 1'b0;
      output_limited_out <= 1'b0;
    end else begin
      pid_active_out    <= active_r;
      sample_strobe_out <= tick_r && active_r;
      if (!active_r) begin
        regulator_out      <= '0;
        limited_r          <= 1'b0;
        output_limited_out <= 1'b0;
      end else if (tick_r) begin
        regulator_out      <= out_nxt[VAL_W-1:0];
        limited_r          <= (sum >= upper_r) || (sum <= lower_r);
        output_limited_out <= (sum >= upper_r) || (sum <= lower_r);
      end
    end
  end

  property p_mode;
    @(posedge clk_in) disable iff (!rst_n_in)
      mode_nxt |=> ##1 pid_active_out;
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode not followed");

  property p_period;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tick_r && period_cycles > 1 && active_r) |=> !tick_r;
  endproperty
  a_period: assert property (p_period) else $error("sample tick too frequent");

  property p_clamp;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tick_r && active_r) |=> (sx(regulator_out) <= $past(upper_r)) &&
                               (sx(regulator_out) >= $past(lower_r));
  endproperty
  a_clamp: assert property (p_clamp) else $error("output outside limits");

  property p_prop_only;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tick_r && active_r && integ_time_r == 0 && deriv_time_r == 0 && integ_r == 0 &&
       p_term <= upper_r && p_term >= lower_r) |=> sx(regulator_out) == $past(p_term);
  endproperty
  a_prop_only: assert property (p_prop_only) else $error("proportional path wrong");

  property p_integ_grows;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tick_r && active_r && !halt_now && inc > 0 && integ_r < PCT_FULL)
        |=> integ_r > $past(integ_r);
  endproperty
  a_integ_grows: assert property (p_integ_grows) else $error("integral stalled");

  property p_no_deriv;
    @(posedge clk_in) disable iff (!rst_n_in)
      (deriv_time_r == 0) |-> d_term == 0;
  endproperty
  a_no_deriv: assert property (p_no_deriv) else $error("derivative with zero time");

  property p_deriv_rate;
    @(posedge clk_in) disable iff (!rst_n_in)
      (dev == dev_prev_r) |-> d_term == 0;
  endproperty
  a_deriv_rate: assert property (p_deriv_rate) else $error("derivative without change");

  property p_dead_band;
    @(posedge clk_in) disable iff (!rst_n_in)
      (abs_dev <= lim_r) |-> (dev == 0 && p_term == 0);
  endproperty
  a_dead_band: assert property (p_dead_band) else $error("deviation limit ignored");

  property p_halt;
    @(posedge clk_in) disable iff (!rst_n_in)
      (tick_r && active_r && halt_now) |=> $stable(integ_r);
  endproperty
  a_halt: assert property (p_halt) else $error("integration not halted");

  c_sample: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    sample_strobe_out ##1 !sample_strobe_out);
  c_limited: cover property (@(posedge clk_in) disable iff (!rst_n_in) output_limited_out);
  c_inverted: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    tick_r && active_r && pol_r && dev != 0);
endmodule

// file: dv/pid_source_model.sv
`timescale 1ns/1ps
// analog, pulse and field-bus sources; each answers one clock late, like a converter
// register, so the regulator never sees a new value in the cycle it was set
module pid_source_model (
  input  wire logic               clk_in,
  input  wire logic signed [15:0] base_in,
  output logic        [10:0][15:0] src_out
);
  // source k carries base plus k+1, so every selector code yields a distinct value
  always_ff @(posedge clk_in) begin
    for (int k = 0; k < 11; k++) begin
      src_out[k] <= base_in + 16'(k + 1);
    end
  end
endmodule

// file: dv/process_pid_regulator_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module process_pid_regulator_bench;
  import pid_pkg::*;
  localparam int CPM = 4;
  logic                clk_in, rst_n_in, pol, active, strobe, limited;
  logic        [3:0]   fa, fb, vch, rsel, fsel;
  logic signed [15:0]  kpad, upper, lower, base, reg_o, w;
  logic        [15:0]  prop_gain, integ_time, deriv_time, per, dlim, opt;
  logic        [10:0][15:0] src;
  logic        [12:0]  modes [5];
  int                  error_cnt, total_checks, gap, e;

  pid_source_model src_u (.clk_in(clk_in), .base_in(base), .src_out(src));

  process_pid_regulator #(.CYCLES_PER_MS(CPM)) dut_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .frequency_command_select_a_in(fa), .frequency_command_select_b_in(fb),
    .voltage_setup_channel_in(vch), .reference_source_select_in(rsel),
    .keypad_preset_reference_in(kpad), .feedback_source_select_in(fsel),
    .output_polarity_select_in(pol), .proportional_gain_setting_in(prop_gain),
    .integral_time_setting_in(integ_time), .derivative_time_setting_in(deriv_time),
    .sampling_period_setting_in(per), .deviation_limit_setting_in(dlim),
    .output_upper_limit_in(upper), .output_lower_limit_in(lower),
    .control_option_digits_in(opt), .analog_input_one_in(src[0]),
    .analog_input_two_in(src[1]), .analog_input_three_in(src[2]),
    .pulse_input_a_in(src[3]), .multi_step_value_in(src[4]),
    .modbus_value_in(src[5]), .fieldbus_value_in(src[6]), .ethernet_value_in(src[7]),
    .pulse_input_b_in(src[8]), .ethercat_value_in(src[9]), .prog_card_value_in(src[10]),
    .pid_active_out(active), .sample_strobe_out(strobe),
    .output_limited_out(limited), .regulator_out(reg_o));

  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // waits for the next sample strobe; gap is the cycle count since the call
  task automatic smp();
    gap = 0;
    do begin
      @(negedge clk_in);
      gap++;
    end while (strobe !== 1'b1 && gap < 300);
    if (gap >= 300) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, strobe, 1'b1);
    end
  endtask

  // two samples, so the settings shadow and the source registers have caught up
  task automatic chk_p(input int exp);
    smp();
    smp();
    `CHK(reg_o, 16'(exp))
  endtask

  initial begin
    #(20 * 30000);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    rst_n_in = 1'b0;
    fa = 4'h0;
    fb = 4'h0;
    vch = 4'h0;
    rsel = 4'h0;
    fsel = 4'hA;
    pol = 1'b0;
    kpad = 16'sh0000;
    upper = 16'sh03E8;
    lower = -16'sh03E8;
    base = 16'sh0064;
    prop_gain = 16'h0064;
    integ_time = 16'h0000;
    deriv_time = 16'h0000;
    per = 16'h0001;
    dlim = 16'h0000;
    opt = 16'h0000;
    error_cnt = 0;
    total_checks = 0;
    modes = '{{4'h7, 4'h0, 4'h0, 1'b1}, {4'h0, 4'h7, 4'h0, 1'b1},
              {4'h0, 4'h0, 4'h6, 1'b1}, {4'h6, 4'h6, 4'h7, 1'b0}, {4'h0, 4'h0, 4'h6, 1'b1}};
    // counted on rising edges: the clock settling to zero at time zero is no real edge
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    `CHK(active, 1'b0)
    rst_n_in = 1'b1;
    for (int i = 0; i < 5; i++) begin
      {fa, fb, vch} = modes[i][12:1];
      repeat (4) @(negedge clk_in);
      `CHK(active, modes[i][0])
    end
    for (int c = 0; c < 13; c++) begin
      rsel = 4'(c);
      kpad = 16'sh0032;
      e = (c == 0) ? 50 : ((c < 12) ? 100 + c : 0);
      chk_p(e);
    end
    kpad = 16'sh01F4;
    for (int f = 0; f < 11; f++) begin
      rsel = 4'h0;
      fsel = 4'(f);
      e = 500 - ((f < 4) ? 101 + f : ((f < 10) ? 102 + f : 0));
      chk_p(e);
    end
    fsel = 4'h0;
    kpad = 16'sh012C;
    chk_p(199);
    pol = 1'b1;
    chk_p(-199);
    prop_gain = 16'h00C8;
    chk_p(-398);
    pol = 1'b0;
    prop_gain = 16'h0064;
    fsel = 4'hA;
    upper = 16'sh00C8;
    kpad = 16'sh0258;
    chk_p(200);
    `CHK(limited, 1'b1)
    kpad = -16'sh0320;
    lower = -16'sh012C;
    chk_p(-300);
    upper = 16'sh03E8;
    lower = -16'sh03E8;
    kpad = 16'sh05DC;
    prop_gain = 16'h0032;
    chk_p(500);
    `CHK(limited, 1'b0)
    prop_gain = 16'h0064;
    dlim = 16'h0064;
    kpad = 16'sh0050;
    chk_p(0);
    kpad = 16'sh0096;
    chk_p(150);
    dlim = 16'h0000;
    per = 16'h0002;
    smp();
    smp();
    smp();
    `CHK(gap, 2 * CPM)
    // derivative at 2 ms: change times deriv_time*10 / 2
    prop_gain = 16'h0000;
    deriv_time = 16'h0001;
    kpad = 16'sh001E;
    chk_p(0);
    kpad = 16'sh0032;
    smp();
    `CHK(reg_o, 16'sh0064)
    smp();
    `CHK(reg_o, 16'sh0000)
    deriv_time = 16'h0000;
    kpad = 16'sh005A;
    smp();
    `CHK(reg_o, 16'sh0000)
    // integral at 2 ms and integ_time 0.01 s: deviation 90 adds 18 per sample
    integ_time = 16'h0001;
    smp();
    smp();
    w = reg_o;
    smp();
    `CHK(16'(reg_o - w), 16'sh0012)
    // leaving the mode clears the accumulator, so the halt case starts from zero
    vch = 4'h0;
    repeat (4) @(negedge clk_in);
    `CHK(reg_o, 16'sh0000)
    opt = 16'h0001;
    upper = 16'sh001E;
    vch = 4'h6;
    repeat (6) smp();
    `CHK(limited, 1'b1)
    upper = 16'sh03E8;
    smp();
    `CHK(reg_o < 16'sh0064, 1'b1)
    tally_and_finish();
  end
endmodule
